/* src/tfe_top.v */
// Error check, attention and exception logic of a magnetic tape formatter.
`include "tfe_regs.vh"

module tfe_top #(
    parameter DATA_W = `TFE_DATA_W,
    parameter ADDR_W = `TFE_ADDR_W
) (
    input  wire              sys_clk,
    input  wire              rstn,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_wpar,
    input  wire              reg_we,
    input  wire              reg_re,
    output reg  [DATA_W-1:0] reg_rdata,
    input  wire [2:0]        unit_sel_pin,
    input  wire              bus_init,
    input  wire              drive_unsafe,
    input  wire [15:0]       hw_err,
    input  wire              op_done,
    input  wire              xfer_startup,
    input  wire              slave_change_bit,
    input  wire              tape_end_marker,
    output wire              composite_fault_signal,
    output wire              service_request_line,
    output reg               busy_line,
    output reg               abnormal_line,
    output reg               transfer_end_line,
    output reg               write_finish,
    output reg               op_start,
    output reg  [4:0]        op_func
);

    // Which hardware error events an operation may raise.
    // Load flags come from the register access itself (bad function also from hw_err while an operation runs) and are masked out of the event path.
    function [15:0] allowed_mask;
        input [4:0] fn;
        begin
            case (fn)
                `TFE_FN_NOP, `TFE_FN_REWOFF, `TFE_FN_REWIND: begin
                    allowed_mask = `TFE_M_LOAD | 16'h0012;
                end
                `TFE_FN_DCLR: begin
                    allowed_mask = `TFE_M_LOAD | 16'h0002;
                end
                `TFE_FN_WTM: begin
                    allowed_mask = `TFE_M_LOAD | 16'h03b6;
                end
                `TFE_FN_ERASE: begin
                    allowed_mask = `TFE_M_LOAD | 16'h0032;
                end
                `TFE_FN_SPFWD, `TFE_FN_SPREV: begin
                    allowed_mask = `TFE_M_LOAD | 16'h0056;
                end
                `TFE_FN_WCHKF, `TFE_FN_WCHKR, `TFE_FN_RDF, `TFE_FN_RDR: begin
                    allowed_mask = 16'hfbff;
                end
                `TFE_FN_WRF: begin
                    allowed_mask = 16'hffff;
                end
                default: begin
                    allowed_mask = 16'h0000;
                end
            endcase
        end
    endfunction

    // Transfer functions move data over the bus, so they alone can end a block or run busy.
    function is_xfer;
        input [4:0] fn;
        begin
            is_xfer = (fn == `TFE_FN_WCHKF) || (fn == `TFE_FN_WCHKR) || (fn == `TFE_FN_WRF) ||
                      (fn == `TFE_FN_RDF) || (fn == `TFE_FN_RDR);
        end
    endfunction

    // A function code that may raise no flag at all is one the formatter does not know.
    function is_known;
        input [4:0] fn;
        begin
            is_known = (allowed_mask(fn) != 16'h0000);
        end
    endfunction

    // Unit jumpers come from pins; a new value is taken once the last two stages agree.
    reg [2:0] unit_s1_reg;
    reg [2:0] unit_s2_reg;
    reg [2:0] unit_s3_reg;
    reg [2:0] unit_reg;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            unit_s1_reg <= 3'h0;
            unit_s2_reg <= 3'h0;
            unit_s3_reg <= 3'h0;
            unit_reg    <= 3'h0;
        end else begin
            unit_s1_reg <= unit_sel_pin;
            unit_s2_reg <= unit_s1_reg;
            unit_s3_reg <= unit_s2_reg;
            if (unit_s2_reg == unit_s3_reg) begin
                unit_reg <= unit_s3_reg;
            end
        end
    end

    // Operation state. The start bit is what makes an ordinary register write refused,
    // so it must fall at completion or a stuck operation would lock out every write but maintenance and attention summary.
    reg        start_reg;
    reg [4:0]  func_reg;
    reg [15:0] err_reg;
    reg [15:0] maint_reg;
    reg [15:0] tapectl_reg;
    reg        ata_reg;
    reg        xfer_reg;
    reg        op_err_reg;
    reg        schg_reg;
    reg        tend_reg;

    // Write decode. A write with bad parity is dropped but still flags the fault; a refused
    // write leaves its target register untouched.
    wire wr_cmd    = reg_we && (reg_addr == `TFE_REG_CMD);
    wire wr_maint  = reg_we && (reg_addr == `TFE_REG_MAINT);
    wire wr_service_request_line   = reg_we && (reg_addr == `TFE_REG_SERVICE_REQUEST_LINE);
    wire wr_tc     = reg_we && (reg_addr == `TFE_REG_TAPECTL);
    wire addr_ok   = (reg_addr == `TFE_REG_CMD) || (reg_addr == `TFE_REG_STATUS) ||
                     (reg_addr == `TFE_REG_ERROR) || (reg_addr == `TFE_REG_MAINT) ||
                     (reg_addr == `TFE_REG_SERVICE_REQUEST_LINE) || (reg_addr == `TFE_REG_TAPECTL);
    wire shared_wr = wr_maint || wr_service_request_line;
    wire par_bad   = reg_we && !(^{reg_wdata, reg_wpar});
    wire bad_reg   = (reg_we || reg_re) && !addr_ok;
    wire refused   = reg_we && addr_ok && !shared_wr && start_reg;
    wire wr_ok     = reg_we && addr_ok && !refused && !par_bad;
    wire go_wr     = wr_cmd && wr_ok && reg_wdata[`TFE_CMD_START];
    wire [4:0] new_fn = reg_wdata[`TFE_CMD_FUNC_HI:`TFE_CMD_FUNC_LO];

    // Composite fault is taken straight from the register, so it drops in the cycle the flags clear.
    assign composite_fault_signal = |err_reg;
    assign service_request_line   = ata_reg;

    // A start while any flag is set never launches. The load becomes a prior-fault pulse
    // that raises attention, so software always hears about a fault it has not cleared.
    wire prior_fault_pulse = go_wr && composite_fault_signal;
    wire bad_fn_load       = go_wr && !composite_fault_signal && !is_known(new_fn);
    wire launch            = go_wr && !composite_fault_signal && is_known(new_fn);
    wire active            = start_reg || xfer_reg;

    // Hardware error events count only while an operation that may raise them runs.
    // An event arriving with no operation running belongs to no function and is dropped.
    wire [15:0] hw_set   = active ? (hw_err & allowed_mask(func_reg) & ~`TFE_M_LOAD) : 16'h0000;
    wire        init_haz = bus_init && drive_unsafe;

    // Flags raised by the register access itself, plus the bus initialize hazard and the hardware hazard and bad-function events, whatever function is running.
    reg [15:0] load_set;
    always @* begin
        load_set = 16'h0000;
        load_set[`TFE_E_BADREG]  = bad_reg;
        load_set[`TFE_E_REFUSED] = refused && !shared_wr;
        load_set[`TFE_E_CONTROL_PARITY_FLAG]    = par_bad && addr_ok;
        load_set[`TFE_E_BADFN]   = bad_fn_load;
        load_set[`TFE_E_HAZARD]  = init_haz || (hw_err[`TFE_E_HAZARD] && active);
        load_set[`TFE_E_BADFN]   = load_set[`TFE_E_BADFN] | (hw_err[`TFE_E_BADFN] && active);
    end

    wire [15:0] err_set = hw_set | load_set;
    // Drive clear wipes flags and attention, but it cannot launch while a flag is set,
    // so in practice only bus initialize recovers from a fault.
    wire        dclr    = launch && (new_fn == `TFE_FN_DCLR);
    wire        done_ev = op_done && start_reg;

    // Flags are sticky; a new event in the clearing cycle still lands.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err_reg <= 16'h0000;
        end else if (dclr || bus_init) begin
            err_reg <= err_set;
        end else begin
            err_reg <= err_reg | err_set;
        end
    end

    // Attention. Set terms are tested before clear terms, so an event that meets a summary
    // write or a drive clear in the same cycle is not lost.
    wire service_request_line_clr  = wr_service_request_line && !par_bad && reg_wdata[unit_reg];
    wire done_service_request_line = done_ev && ((func_reg == `TFE_FN_ERASE) || (func_reg == `TFE_FN_WTM) ||
                     (func_reg == `TFE_FN_SPFWD) || (func_reg == `TFE_FN_SPREV) ||
                     op_err_reg || (|hw_set) || schg_reg || tend_reg);
    wire rew_service_request_line  = launch && ((new_fn == `TFE_FN_REWIND) || (new_fn == `TFE_FN_REWOFF));
    wire service_request_line_set  = prior_fault_pulse || bad_fn_load || done_service_request_line || rew_service_request_line;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ata_reg <= 1'b0;
        end else if (service_request_line_set) begin
            ata_reg <= 1'b1;
        end else if (service_request_line_clr || dclr || bus_init) begin
            ata_reg <= 1'b0;
        end
    end

    // Rewinds run on in the transport, so they do not hold the start bit.
    wire holds_start = launch && (new_fn != `TFE_FN_REWIND) && (new_fn != `TFE_FN_REWOFF) &&
                       (new_fn != `TFE_FN_DCLR) && (new_fn != `TFE_FN_NOP);

    // Per-operation record of error, slave change and tape end; completion reads it to
    // decide whether attention is due, then the next held launch wipes it.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            start_reg  <= 1'b0;
            func_reg   <= 5'h00;
            xfer_reg   <= 1'b0;
            op_err_reg <= 1'b0;
            schg_reg   <= 1'b0;
            tend_reg   <= 1'b0;
            op_start   <= 1'b0;
            op_func    <= 5'h00;
            busy_line  <= 1'b0;
        end else begin
            op_start  <= launch && !dclr;
            busy_line <= xfer_reg && !done_ev && !bus_init;
            if (bus_init || prior_fault_pulse) begin
                start_reg <= 1'b0;
                xfer_reg  <= 1'b0;
            end else if (holds_start) begin
                start_reg  <= 1'b1;
                func_reg   <= new_fn;
                op_func    <= new_fn;
                xfer_reg   <= is_xfer(new_fn);
                op_err_reg <= 1'b0;
                schg_reg   <= 1'b0;
                tend_reg   <= 1'b0;
            end else if (launch) begin
                func_reg <= new_fn;
                op_func  <= new_fn;
            end else if (done_ev) begin
                start_reg <= 1'b0;
                xfer_reg  <= 1'b0;
            end else begin
                op_err_reg <= op_err_reg | (|hw_set);
                schg_reg   <= schg_reg | slave_change_bit;
                tend_reg   <= tend_reg | tape_end_marker;
            end
        end
    end

    // End-of-block causes. A read ends the bus transfer on a data error only at startup or with abort
    // enabled; a write always ends, since the record on tape is bad anyway.
    wire is_read  = (func_reg == `TFE_FN_RDF) || (func_reg == `TFE_FN_RDR) ||
                    (func_reg == `TFE_FN_WCHKF) || (func_reg == `TFE_FN_WCHKR);
    wire is_write = (func_reg == `TFE_FN_WRF);
    wire abort_en = tapectl_reg[`TFE_TC_ABORT];
    wire data_err = |(hw_set & `TFE_M_DATA);
    wire b_err    = |(hw_set & `TFE_M_CLASSB);
    // Any new flag counts, a refused or bad write during the transfer as well as a tape event.
    wire any_xerr = xfer_reg && (|err_set);
    wire ebl_ev   = (go_wr && composite_fault_signal && is_xfer(new_fn)) ||
                    (xfer_reg && xfer_startup && (|hw_set)) ||
                    (xfer_reg && b_err) ||
                    (xfer_reg && is_read && data_err && abort_en) ||
                    (xfer_reg && is_write && data_err);
    wire wfin_ev  = xfer_reg && is_write && (data_err || b_err);

    // The transfer ends on the bus but a read keeps running until the tape stops.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            abnormal_line     <= 1'b0;
            transfer_end_line <= 1'b0;
            write_finish      <= 1'b0;
        end else begin
            write_finish <= wfin_ev;
            if (launch || bus_init) begin
                abnormal_line     <= 1'b0;
                transfer_end_line <= ebl_ev;
            end else begin
                abnormal_line     <= abnormal_line | any_xerr;
                transfer_end_line <= transfer_end_line | ebl_ev;
            end
        end
    end

    // Maintenance and tape control are plain storage that bus initialize returns to reset.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            maint_reg   <= `TFE_MAINT_RST;
            tapectl_reg <= `TFE_TAPECTL_RST;
        end else if (bus_init) begin
            maint_reg   <= `TFE_MAINT_RST;
            tapectl_reg <= `TFE_TAPECTL_RST;
        end else begin
            if (wr_maint && wr_ok) begin
                maint_reg <= reg_wdata;
            end
            if (wr_tc && wr_ok) begin
                tapectl_reg <= reg_wdata;
            end
        end
    end

    // Read multiplexer. The summary lane follows the synchronised unit number, so a jumper
    // change shows up only once the synchroniser has settled.
    reg [15:0] status_w;
    reg [15:0] rd_next;
    always @* begin
        status_w = 16'h0000;
        status_w[`TFE_ST_SERVICE_REQUEST_LINE]  = ata_reg;
        status_w[`TFE_ST_FAULT] = composite_fault_signal;
        status_w[`TFE_ST_BUSY]  = xfer_reg;
        status_w[`TFE_ST_SCHG]  = schg_reg;
        status_w[`TFE_ST_TEND]  = tend_reg;
        status_w[`TFE_ST_START] = start_reg;
        rd_next = 16'h0000;
        case (reg_addr)
            `TFE_REG_CMD: begin
                rd_next = {10'h000, func_reg, start_reg};
            end
            `TFE_REG_STATUS: begin
                rd_next = status_w;
            end
            `TFE_REG_ERROR: begin
                rd_next = err_reg;
            end
            `TFE_REG_MAINT: begin
                rd_next = maint_reg;
            end
            `TFE_REG_SERVICE_REQUEST_LINE: begin
                rd_next[unit_reg] = ata_reg;
            end
            `TFE_REG_TAPECTL: begin
                rd_next = tapectl_reg;
            end
            default: begin
                rd_next = 16'h0000;
            end
        endcase
    end

    // Read data stand for one cycle and are zero otherwise, so a stale word is never taken
    // for a later answer.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_re) begin
            reg_rdata <= rd_next;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

/* src/tfe_regs.vh */
// Register map, field positions, function codes and reset values of the tape formatter error logic.
`ifndef TFE_REGS_VH
`define TFE_REGS_VH

`define TFE_ADDR_W        5
`define TFE_DATA_W        16

`define TFE_REG_CMD       5'h00
`define TFE_REG_STATUS    5'h01
`define TFE_REG_ERROR     5'h02
`define TFE_REG_MAINT     5'h03
`define TFE_REG_SERVICE_REQUEST_LINE      5'h04
`define TFE_REG_TAPECTL   5'h09

`define TFE_CMD_START     0
`define TFE_CMD_FUNC_LO   1
`define TFE_CMD_FUNC_HI   5

`define TFE_FN_NOP        5'h00
`define TFE_FN_REWOFF     5'h01
`define TFE_FN_REWIND     5'h03
`define TFE_FN_DCLR       5'h04
`define TFE_FN_ERASE      5'h0a
`define TFE_FN_WTM        5'h0b
`define TFE_FN_SPFWD      5'h0c
`define TFE_FN_SPREV      5'h0d
`define TFE_FN_WCHKF      5'h14
`define TFE_FN_WCHKR      5'h17
`define TFE_FN_WRF        5'h18
`define TFE_FN_RDF        5'h1c
`define TFE_FN_RDR        5'h1f

`define TFE_E_BADFN       15
`define TFE_E_BADREG      14
`define TFE_E_REFUSED     13
`define TFE_E_CONTROL_PARITY_FLAG        12
`define TFE_E_FORMAT      11
`define TFE_E_XPAR        10
`define TFE_E_VPAR        9
`define TFE_E_LCHK        8
`define TFE_E_GAP         7
`define TFE_E_COUNT       6
`define TFE_E_SKEW        5
`define TFE_E_NONEXEC     4
`define TFE_E_TIMING      3
`define TFE_E_INCOMP      2
`define TFE_E_HAZARD      1
`define TFE_E_CRC         0

`define TFE_M_LOAD        16'hf000
`define TFE_M_DATA        16'h0701
`define TFE_M_CLASSB      16'h800e

`define TFE_ST_SERVICE_REQUEST_LINE       15
`define TFE_ST_FAULT      14
`define TFE_ST_BUSY       13
`define TFE_ST_SCHG       12
`define TFE_ST_TEND       11
`define TFE_ST_START      10

`define TFE_TC_ABORT      12

`define TFE_MAINT_RST     16'h0000
`define TFE_TAPECTL_RST   16'h0000

`endif

/* test/tfe_top_monitor.sv */
// Port checker for the tape formatter error logic.
module tfe_top_monitor (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wpar,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0]  unit_sel_pin,
    input wire logic        bus_init,
    input wire logic        op_done,
    input wire logic        composite_fault_signal,
    input wire logic        service_request_line,
    input wire logic        busy_line,
    input wire logic        abnormal_line,
    input wire logic        transfer_end_line,
    input wire logic        write_finish,
    input wire logic        op_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Parity is folded in so that a load refused for parity is not taken for a launch attempt.
    wire go_load = reg_we && reg_addr == 5'h00 && reg_wdata[0] && (^{reg_wdata, reg_wpar});
    wire fault = composite_fault_signal;
    AST_NO_LAUNCH: assert property (go_load && fault |=> !op_start)
        else $error("launch despite fault");
    AST_PRIOR_BUSY: assert property (go_load && fault && !busy_line |-> ##2 !busy_line)
        else $error("busy raised despite fault");
    AST_PRIOR_SERVICE_REQUEST_LINE: assert property (go_load && fault |=> service_request_line)
        else $error("no service request after faulty load");
    AST_STICKY: assert property (fault && op_done && !bus_init && !reg_we |=> fault)
        else $error("fault lost at completion");
    AST_ABN_CAUSE: assert property ($rose(abnormal_line) |-> fault)
        else $error("abnormal line without fault");
    AST_END_CAUSE: assert property ($rose(transfer_end_line) |-> fault)
        else $error("end of block without fault");
    AST_WFIN: assert property (write_finish |-> transfer_end_line ##1 !write_finish)
        else $error("write finish out of place");
    AST_SERVICE_REQUEST_LINE_READ: assert property (reg_re && reg_addr == 5'h04 |=>
        reg_rdata == ($past(service_request_line) ? 16'h0001 << unit_sel_pin : 16'h0000))
        else $error("summary lane wrong");
    AST_SERVICE_REQUEST_LINE_KEEP: assert property (service_request_line && reg_we && reg_addr == 5'h04 &&
        !reg_wdata[unit_sel_pin] && !bus_init |=> service_request_line)
        else $error("flag cleared by low lane");
endmodule
bind tfe_top tfe_top_monitor i_tfe_top_monitor (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wpar,
    .reg_we, .reg_re, .reg_rdata, .unit_sel_pin, .bus_init, .op_done, .composite_fault_signal,
    .service_request_line, .busy_line, .abnormal_line, .transfer_end_line, .write_finish, .op_start);

/* test/tfe_ctl.sv */
// Bus controller model: register cycles and the attention service routine.
module tfe_ctl (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    output logic      [4:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wpar,
    output logic             reg_we,
    output logic             reg_re
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 5'h1e;
        reg_wdata = 16'h5a5a;
        reg_wpar = 1'b0;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end
    // Idle data is inverted so that a design reading it outside a strobe sees garbage.
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic bad);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wpar <= ~(^d) ^ bad;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic service(input logic [2:0] u, output logic [15:0] sm, st, er);
        rd(5'h04, sm);
        rd(5'h01, st);
        er = 16'h0000;
        if (st[14]) rd(5'h02, er);
        if (sm[u]) wr(5'h04, 16'h0001 << u, 1'b0);
    endtask
endmodule

/* test/tb_tfe_top.sv */
// Self-checking bench for the tape formatter error logic.
`include "tfe_regs.vh"
module tb_tfe_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rstn = 0, bus_init = 0, drive_unsafe = 0, op_done = 0, xfer_startup = 0;
    logic slave_change_bit = 0, tape_end_marker = 0;
    logic [2:0] unit_sel_pin = 3'h5;
    logic [15:0] hw_err = 16'h0000, v, s, e;
    wire [4:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata;
    wire reg_wpar, reg_we, reg_re, fault, srq, busy, abn, tend, wfin, ostart;
    wire [4:0] ofunc;
    int bad_count = 0, total_checks = 0;
    tfe_top i_tfe_top (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wpar, .reg_we, .reg_re, .reg_rdata,
        .unit_sel_pin, .bus_init, .drive_unsafe, .hw_err, .op_done, .xfer_startup, .slave_change_bit,
        .tape_end_marker, .composite_fault_signal(fault), .service_request_line(srq), .busy_line(busy),
        .abnormal_line(abn), .transfer_end_line(tend), .write_finish(wfin), .op_start(ostart),
        .op_func(ofunc));
    tfe_ctl i_tfe_ctl (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wpar, .reg_we, .reg_re);
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        total_checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic init(input logic u);
        @(posedge sys_clk);
        bus_init <= 1'b1;
        drive_unsafe <= u;
        xfer_startup <= 1'b0;
        @(posedge sys_clk);
        bus_init <= 1'b0;
        #1;
    endtask
    task automatic pulse(input logic [15:0] er, input logic dn);
        @(posedge sys_clk);
        hw_err <= er;
        op_done <= dn;
        @(posedge sys_clk);
        hw_err <= 16'h0000;
        op_done <= 1'b0;
        #1;
    endtask
    task automatic go(input logic [4:0] fn);
        i_tfe_ctl.wr(`TFE_REG_CMD, {10'h000, fn, 1'b1}, 1'b0);
        #1;
    endtask
    task automatic t_prior;
        logic [4:0] fns [12] = '{`TFE_FN_NOP, `TFE_FN_REWOFF, `TFE_FN_REWIND, `TFE_FN_ERASE, `TFE_FN_WTM,
            `TFE_FN_SPFWD, `TFE_FN_SPREV, `TFE_FN_WCHKF, `TFE_FN_WCHKR, `TFE_FN_WRF, `TFE_FN_RDF, `TFE_FN_RDR};
        init(1'b1);
        chk("fault", 16'h1, fault);
        i_tfe_ctl.rd(`TFE_REG_ERROR, v);
        chk("init err", 16'h0002, v);
        i_tfe_ctl.rd(5'h1f, v);
        chk("unmapped", 16'h0000, v);
        i_tfe_ctl.wr(`TFE_REG_MAINT, 16'h0003, 1'b1);
        foreach (fns[i]) begin
            go(fns[i]);
            chk("no launch", 16'h0, ostart);
            chk("prior service_request_line", 16'h1, srq);
            tick;
            chk("no busy", 16'h0, busy);
            chk("end on fault", fns[i] >= 5'h14, tend);
            i_tfe_ctl.wr(`TFE_REG_SERVICE_REQUEST_LINE, 16'h0004, 1'b0);
            chk("service_request_line kept", 16'h1, srq);
            i_tfe_ctl.service(3'h5, v, s, e);
            chk("summary", 16'h0020, v);
            chk("status", 16'hc000, s);
            chk("err", 16'h5002, e);
            chk("service_request_line clear", 16'h0, srq);
        end
    endtask
    task automatic t_erase;
        init(1'b0);
        go(`TFE_FN_ERASE);
        chk("launch", 16'h1, ostart);
        chk("func", `TFE_FN_ERASE, ofunc);
        i_tfe_ctl.wr(`TFE_REG_TAPECTL, 16'h1000, 1'b0);
        pulse(16'h0060, 1'b0);
        chk("early service_request_line", 16'h0, srq);
        pulse(16'h0000, 1'b1);
        chk("erase service_request_line", 16'h1, srq);
        chk("sticky", 16'h1, fault);
        i_tfe_ctl.rd(`TFE_REG_ERROR, v);
        chk("erase err", 16'h2020, v);
        i_tfe_ctl.rd(`TFE_REG_TAPECTL, v);
        chk("refused", 16'h0000, v);
    endtask
    task automatic t_motion;
        logic [4:0] fns [4] = '{`TFE_FN_REWOFF, `TFE_FN_REWIND, `TFE_FN_NOP, 5'h02};
        foreach (fns[i]) begin
            init(1'b0);
            go(fns[i]);
            tick;
            chk("rewind service_request_line", i != 2, srq);
            chk("bad function", i == 3, fault);
        end
        init(1'b0);
        go(`TFE_FN_REWIND);
        go(`TFE_FN_DCLR);
        chk("clear no launch", 16'h0, ostart);
        chk("clear service_request_line", 16'h0, srq);
    endtask
    task automatic t_xfer;
        logic [4:0] fn [6] = '{`TFE_FN_RDF, `TFE_FN_RDF, `TFE_FN_RDR, `TFE_FN_WRF, `TFE_FN_WCHKF, `TFE_FN_RDF};
        logic [15:0] er [6] = '{16'h0200, 16'h0200, 16'h0004, 16'h0400, 16'h0001, 16'h0100};
        logic ab [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic te [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        logic su [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        foreach (fn[i]) begin
            init(1'b0);
            i_tfe_ctl.wr(`TFE_REG_TAPECTL, {3'h0, ab[i], 12'h000}, 1'b0);
            go(fn[i]);
            tick;
            chk("busy", 16'h1, busy);
            @(posedge sys_clk);
            xfer_startup <= su[i];
            pulse(er[i], 1'b0);
            chk("abnormal", 16'h1, abn);
            chk("end of block", te[i], tend);
            chk("write finish", fn[i] == `TFE_FN_WRF, wfin);
            i_tfe_ctl.rd(`TFE_REG_STATUS, s);
            if (fn[i] != `TFE_FN_WRF) chk("read goes on", 16'h1, s[10]);
        end
    endtask
    task automatic t_end;
        for (int i = 0; i < 3; i++) begin
            init(1'b0);
            go(`TFE_FN_RDF);
            @(posedge sys_clk);
            tape_end_marker <= (i == 0);
            slave_change_bit <= (i == 1);
            @(posedge sys_clk);
            tape_end_marker <= 1'b0;
            slave_change_bit <= 1'b0;
            pulse(16'h0000, 1'b1);
            chk("end service_request_line", i < 2, srq);
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_prior;
        t_erase;
        t_motion;
        t_xfer;
        t_end;
        close_out;
    end
    // The whole sequence takes well under 2000 cycles; this leaves a wide margin.
    initial begin
        #40000;
        bad_count++;
        close_out;
    end
endmodule
